// file: core/rfd_map.vh
`ifndef RFD_MAP_VH
`define RFD_MAP_VH

// Data widths
`define RFD_ANG_W      12
`define RFD_TRIG_W     12
`define RFD_MON_W      16

// Monitor thresholds in monitor units
`define RFD_MON_MIN    16'h2300
`define RFD_MON_MAX    16'h4100
`define RFD_MISMATCH   16'h0600

// Angle thresholds in LSB of a 12-bit circle (4096 per turn)
`define RFD_ERR_SET    12'h039
`define RFD_ERR_CLR    12'h00B

// Rate limit in LSB per position step
`define RFD_VEL_MAX    12'h200

// Reset values
`define RFD_MIN_INIT   16'hFFFF
`define RFD_MAX_INIT   16'h0000
`define RFD_ANG_INIT   12'h000

`endif

// file: core/rfd_trig.v
`timescale 1ns/1ps
`default_nettype none
`include "rfd_map.vh"

// Sine and cosine from a piecewise-linear quarter wave folded by symmetry.
// Coarse but cheap; the monitor thresholds leave room for its error.
module rfd_trig (
  // Angle
  input  wire [`RFD_ANG_W-1:0]         angle_i,
  // Results, signed Q1.11
  output reg  signed [`RFD_TRIG_W-1:0] sin_o,
  output reg  signed [`RFD_TRIG_W-1:0] cos_o
);

  reg [10:0] q_sin;
  reg [10:0] q_cos;
  reg [9:0]  idx;
  reg [9:0]  idx_c;

  // Linear-segment sine on a quarter wave: cheap, but up to about a quarter low near 45 degrees
  function [10:0] quarter_sine;
    input [9:0] a;
    reg   [11:0] t;
    begin
      t = 12'h000;
      if (a < 10'h100) begin
        t = {1'b0, a, 1'b0} + {2'b00, a[9:0]} - {4'h0, a[9:2]};
      end else if (a < 10'h200) begin
        t = 12'h2C0 + ({2'b00, a} - 12'h100) + ({2'b00, a} - 12'h100) / 12'h002;
      end else if (a < 10'h300) begin
        t = 12'h5C0 + ({2'b00, a} - 12'h200);
      end else begin
        t = 12'h6C0 + ({2'b00, a} - 12'h300) / 12'h004;
      end
      quarter_sine = (t > 12'h7FF) ? 11'h7FF : t[10:0];
    end
  endfunction

  // Fold the angle into one quadrant and restore signs
  always @* begin
    idx   = angle_i[10] ? ~angle_i[9:0] : angle_i[9:0];
    idx_c = angle_i[10] ? angle_i[9:0] : ~angle_i[9:0];
    q_sin = quarter_sine(idx);
    q_cos = quarter_sine(idx_c);
    sin_o = angle_i[11] ? -$signed({1'b0, q_sin}) : $signed({1'b0, q_sin});
    cos_o = (angle_i[11] ^ angle_i[10]) ? -$signed({1'b0, q_cos}) : $signed({1'b0, q_cos});
  end

endmodule
`default_nettype wire

// file: core/rfd_fault.v
`timescale 1ns/1ps
`default_nettype none
`include "rfd_map.vh"

module rfd_fault (
  // Clock and reset
  input  wire                          clk_i,
  input  wire                          reset_n_i,
  // Demodulated resolver inputs, signed
  input  wire signed [`RFD_TRIG_W-1:0] sin_in_i,
  input  wire signed [`RFD_TRIG_W-1:0] cos_in_i,
  // Tracking loop state
  input  wire [`RFD_ANG_W-1:0]         pos_integ_i,
  input  wire [`RFD_ANG_W-1:0]         vel_integ_i,
  input  wire [`RFD_ANG_W-1:0]         loop_err_i,
  // Sampling strobe, active low
  input  wire                          sample_n_i,
  // Held values
  output reg  [`RFD_ANG_W-1:0]         pos_held_o,
  output reg  [`RFD_ANG_W-1:0]         vel_held_o,
  // Fault outputs, active low
  output reg                           signal_degraded_n_o,
  output reg                           tracking_lost_n_o
);

  reg                          sample_d_r;
  reg                          loss_latch_r;
  reg                          mism_latch_r;
  reg                          lot_err_r;
  reg                          lot_vel_r;
  reg  [`RFD_MON_W-1:0]        mon_min_r;
  reg  [`RFD_MON_W-1:0]        mon_max_r;
  reg  [`RFD_MON_W-1:0]        mon_mag_r;
  reg  [`RFD_ANG_W-1:0]        pos_prev_r;
  reg  [`RFD_ANG_W-1:0]        rate_r;
  wire signed [`RFD_TRIG_W-1:0] sin_phi;
  wire signed [`RFD_TRIG_W-1:0] cos_phi;
  wire signed [23:0]           prod_s;
  wire signed [23:0]           prod_c;
  wire signed [24:0]           mon_sum;
  wire [`RFD_MON_W-1:0]        mon_abs;
  wire [`RFD_ANG_W-1:0]        gap_raw;
  wire [`RFD_ANG_W-1:0]        gap_mag;
  wire [`RFD_ANG_W-1:0]        err_mag;
  wire [`RFD_ANG_W-1:0]        step_raw;
  wire [`RFD_ANG_W-1:0]        vel_mag;
  wire                         sample_fall;
  wire                         sample_rise;
  wire                         loss_now;
  wire                         over_now;
  wire                         mism_now;
  wire                         err_set;
  wire                         err_clr;
  wire                         vel_set;
  wire                         vel_clr;
  reg                          deg_nxt;
  reg                          lot_nxt;

  // Strobe edges; strobe is already synchronous to the clock
  assign sample_fall = sample_d_r & ~sample_n_i;
  assign sample_rise = ~sample_d_r & sample_n_i;

  // Sine and cosine of the held angle, not the integrator
  rfd_trig u_trig (
    .angle_i (pos_held_o),
    .sin_o   (sin_phi),
    .cos_o   (cos_phi)
  );

  // Monitor value, full 24-bit products kept before scaling
  assign prod_s  = sin_in_i * sin_phi;
  assign prod_c  = cos_in_i * cos_phi;
  assign mon_sum = {prod_s[23], prod_s} + {prod_c[23], prod_c};
  assign mon_abs = mon_sum[24] ? 16'h0000 : mon_sum[22:7];

  // Magnitudes of angle differences on the 12-bit circle
  assign gap_raw  = pos_integ_i - pos_held_o;
  assign gap_mag  = gap_raw[11] ? (~gap_raw + 12'h001) : gap_raw;
  assign err_mag  = loop_err_i[11] ? (~loop_err_i + 12'h001) : loop_err_i;
  assign vel_mag  = vel_integ_i[11] ? (~vel_integ_i + 12'h001) : vel_integ_i;
  assign step_raw = pos_integ_i - pos_prev_r;

  // Raw conditions
  assign loss_now = mon_mag_r < `RFD_MON_MIN;
  assign over_now = mon_mag_r > `RFD_MON_MAX;
  assign mism_now = (mon_max_r > mon_min_r) && ((mon_max_r - mon_min_r) > `RFD_MISMATCH);
  assign err_set  = (err_mag > `RFD_ERR_SET) || (gap_mag > `RFD_ERR_SET);
  assign err_clr  = (err_mag < `RFD_ERR_CLR) && (gap_mag < `RFD_ERR_CLR);
  assign vel_set  = vel_mag > `RFD_VEL_MAX;
  assign vel_clr  = (vel_mag < `RFD_VEL_MAX) && (gap_mag < `RFD_ERR_CLR);

  // Capture held values on the strobe falling edge
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sample_d_r <= 1'b1;
      pos_held_o <= `RFD_ANG_INIT;
      vel_held_o <= `RFD_ANG_INIT;
      pos_prev_r <= `RFD_ANG_INIT;
      rate_r     <= `RFD_ANG_INIT;
      mon_mag_r  <= `RFD_MAX_INIT;
    end else begin
      sample_d_r <= sample_n_i;
      pos_prev_r <= pos_integ_i;
      rate_r     <= step_raw;
      mon_mag_r  <= mon_abs;
      if (sample_fall) begin
        pos_held_o <= pos_integ_i;
        vel_held_o <= vel_integ_i;
      end
    end
  end

  // Min/max store, reset by strobe rising edge
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mon_min_r <= `RFD_MIN_INIT;
      mon_max_r <= `RFD_MAX_INIT;
    end else if (sample_rise) begin
      mon_min_r <= `RFD_MIN_INIT;
      mon_max_r <= `RFD_MAX_INIT;
    end else if (!loss_now) begin
      // Skip lost samples so a dropout does not fake a mismatch
      if (mon_mag_r < mon_min_r) mon_min_r <= mon_mag_r;
      if (mon_mag_r > mon_max_r) mon_max_r <= mon_mag_r;
    end
  end

  // Latches: a new loss in the clearing cycle wins over the clear; for mismatch the clear wins
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      loss_latch_r <= 1'b0;
      mism_latch_r <= 1'b0;
    end else begin
      loss_latch_r <= loss_now | (loss_latch_r & ~sample_rise);
      mism_latch_r <= (mism_now & ~sample_rise) | (mism_latch_r & ~sample_rise);
    end
  end

  // Tracking loss with hysteresis, not latched
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lot_err_r <= 1'b0;
      lot_vel_r <= 1'b0;
    end else begin
      if (err_set) lot_err_r <= 1'b1;
      else if (err_clr) lot_err_r <= 1'b0;
      if (vel_set) lot_vel_r <= 1'b1;
      else if (vel_clr) lot_vel_r <= 1'b0;
    end
  end

  // Priority encoder: loss, then degradation, then tracking
  always @* begin
    deg_nxt = 1'b1;
    lot_nxt = 1'b1;
    if (loss_latch_r || loss_now) begin
      deg_nxt = 1'b0;
      lot_nxt = 1'b0;
    end else if (over_now || mism_latch_r || mism_now) begin
      deg_nxt = 1'b0;
    end else if (lot_err_r || lot_vel_r) begin
      lot_nxt = 1'b0;
    end
  end

  // Registered fault pins; high after reset
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      signal_degraded_n_o <= 1'b1;
      tracking_lost_n_o   <= 1'b1;
    end else begin
      signal_degraded_n_o <= deg_nxt;
      tracking_lost_n_o   <= lot_nxt;
    end
  end

endmodule
`default_nettype wire

// file: test/rfd_resolver_model.sv
`timescale 1ns/1ps
`default_nettype none
// Demodulated resolver windings: amplitude times sin and cos of the shaft angle
module rfd_resolver_model (
  // Shaft angle and winding amplitude
  input  wire logic [11:0]        angle_i,
  input  wire logic [11:0]        amp_i,
  // Demodulated sine and cosine windings
  output var logic signed [11:0] sin_o,
  output var logic signed [11:0] cos_o
);
  real th;
  // Real math keeps the model independent of the coarse table in the design
  always @* begin
    th = 6.283185307 * angle_i / 4096.0;
    sin_o = 12'($rtoi(amp_i * $sin(th)));
    cos_o = 12'($rtoi(amp_i * $cos(th)));
  end
endmodule
`default_nettype wire

// file: test/rfd_fault_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "rfd_map.vh"
module rfd_fault_checker (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  // Loop state and strobe
  input wire logic [11:0] pos_integ_i,
  input wire logic [11:0] vel_integ_i,
  input wire logic [11:0] loop_err_i,
  input wire logic        sample_n_i,
  // Held values and faults
  input wire logic [11:0] pos_held_o,
  input wire logic [11:0] vel_held_o,
  input wire logic        signal_degraded_n_o,
  input wire logic        tracking_lost_n_o
);
  // Magnitude of a two's complement angle; wraps the gap around the circle
  function automatic logic [11:0] mag(input logic [11:0] x);
    mag = x[11] ? -x : x;
  endfunction
  wire [11:0] em = mag(loop_err_i);
  wire [11:0] vm = mag(vel_integ_i);
  wire [11:0] gm = mag(pos_integ_i - pos_held_o);
  wire        dg = signal_degraded_n_o;
  wire        tl = tracking_lost_n_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Strobe held high over three samples cannot have released a latched loss
  loss_latch_a: assert property (!dg && !tl && sample_n_i && $past(sample_n_i) && $past(sample_n_i, 2)
    |=> !dg && !tl) else $error("loss latch released without strobe");
  pos_load_a: assert property ($fell(sample_n_i) |=> pos_held_o == $past(pos_integ_i))
    else $error("held position not loaded");
  vel_load_a: assert property ($fell(sample_n_i) |=> vel_held_o == $past(vel_integ_i))
    else $error("held velocity not loaded");
  held_keep_a: assert property (!$fell(sample_n_i) |=> $stable(pos_held_o) && $stable(vel_held_o))
    else $error("held values moved without strobe");
  err_set_a: assert property ((em > `RFD_ERR_SET) [*3] |-> !tl || !dg)
    else $error("loop error not flagged");
  vel_set_a: assert property ((vm > `RFD_VEL_MAX) [*3] |-> !tl || !dg)
    else $error("overspeed not flagged");
  gap_set_a: assert property ((gm > `RFD_ERR_SET) [*3] |-> !tl || !dg)
    else $error("position gap not flagged");
  err_clear_a: assert property ($rose(tl) && dg && $past(dg) |-> $past(em, 2) < `RFD_ERR_CLR)
    else $error("tracking cleared with loop error");
  gap_clear_a: assert property ($rose(tl) && dg && $past(dg) |-> $past(gm, 2) < `RFD_ERR_CLR)
    else $error("tracking cleared with position gap");
  cover property (!dg && !tl);
  cover property (!dg && tl);
  cover property (dg && !tl);
endmodule
`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0, reset_n_i = 1'b0, sample_n_i = 1'b1;
  logic [11:0] pos_integ_i = 12'h000, vel_integ_i = 12'h000, loop_err_i = 12'h000;
  logic [11:0] ang = 12'h000, amp = 12'h300, p, v;
  wire signed [11:0] sin_in_i, cos_in_i;
  wire [11:0] pos_held_o, vel_held_o;
  wire signal_degraded_n_o, tracking_lost_n_o;
  int num_errors = 0, tests_run = 0, cyc = 0, seed = 33938;
  rfd_resolver_model res (.angle_i(ang), .amp_i(amp), .sin_o(sin_in_i), .cos_o(cos_in_i));
  rfd_fault uut (.*);
  initial forever #25 clk_i = ~clk_i;
  // Fault code by priority: loss over degradation over tracking
  function automatic logic [1:0] enc(input logic l, d, t);
    enc = l ? 2'b00 : d ? 2'b01 : t ? 2'b10 : 2'b11;
  endfunction
  task automatic check_flt(input logic [1:0] e);
    tests_run++;
    if ({signal_degraded_n_o, tracking_lost_n_o} !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t faults %h exp %h", $time, {signal_degraded_n_o, tracking_lost_n_o}, e);
    end
  endtask
  task automatic check_val(input logic [11:0] g, e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t held %h exp %h", $time, g, e);
    end
  endtask
  // Strobe low one cycle; new shaft angle lands with the rise so the monitor never mixes angles
  task automatic pulse(input logic [11:0] a);
    sample_n_i = 1'b0;
    repeat (1) @(negedge clk_i);
    ang = a;
    sample_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
  endtask
  // Four cycles cover the two-stage fault pipeline with margin
  task automatic st(input logic [11:0] a, e, input logic [1:0] x);
    amp = a;
    loop_err_i = e;
    repeat (4) @(negedge clk_i);
    check_flt(x);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Cut a hang short well beyond the roughly 115 cycles the tests need
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      final_report;
    end
  end
  initial begin
    repeat (5) @(negedge clk_i);
    reset_n_i = 1'b1;
    pulse(ang); check_flt(enc(0, 0, 0));
    st(12'h000, 12'h000, enc(1, 0, 0));
    st(12'h300, 12'h000, enc(1, 0, 0));
    pulse(ang); check_flt(enc(0, 0, 0));
    st(12'h600, 12'h000, enc(0, 1, 0));
    st(12'h300, 12'h000, enc(0, 1, 0));
    pulse(ang); check_flt(enc(0, 0, 0));
    $display("loss and degradation done");
    st(12'h300, 12'hFC6, enc(0, 0, 1));
    st(12'h300, 12'h020, enc(0, 0, 1));
    st(12'h300, 12'h00A, enc(0, 0, 0));
    vel_integ_i = 12'h201;
    st(12'h300, 12'h000, enc(0, 0, 1));
    vel_integ_i = 12'h000;
    st(12'h300, 12'h000, enc(0, 0, 0));
    st(12'h000, 12'h03A, enc(1, 0, 1));
    amp = 12'h300;
    pulse(ang); check_flt(enc(0, 0, 1));
    st(12'h600, 12'h03A, enc(0, 1, 1));
    st(12'h300, 12'h000, enc(0, 1, 0));
    pulse(ang); check_flt(enc(0, 0, 0));
    $display("tracking and priority done");
    repeat (4) begin
      p = ang + 12'h400 + (12'($random(seed)) & 12'h7FF);
      v = 12'($random(seed)) & 12'h1FF;
      pos_integ_i = p;
      vel_integ_i = v;
      st(12'h300, 12'h000, enc(0, 0, 1));
      pulse(p);
      check_val(pos_held_o, p);
      check_val(vel_held_o, v);
      check_flt(enc(0, 0, 0));
    end
    $display("random position steps done");
    final_report;
  end
endmodule
bind rfd_fault rfd_fault_checker chk (.*);
`default_nettype wire
